// [design/hber_error_regs.sv]
// error flag and error report enable registers of the host bridge
//
// Notes on behaviour
// - flags set on their condition, whatever the enables say.
// - flags hold until software writes one; zero leaves them.
// - message only on a flag rising or a target abort, with its enable and global enable.
// - every message also gated by global enable in pci command register.
// - no error pin; errors leave as a message request on the hub link.
// - bit 9 set on a lock to memory space outside system dram.
// - bit 8 set only when smi came from the software trigger.
// - bit 5 set on an unimplemented hub link special cycle.
// - bit 4 set on an agp access outside the aperture.
// - bit 3 set on outside-aperture agp access to legacy or above top.
// - bit 2 set when translation lookup returns an invalid entry.
// - bit 1 set on a malformed or unsupported agp command.
// - enable bit 9 reports non-memory lock cycles.
// - enable bit 6 reports target aborts on bridge hub link cycles.
// - enable bit 5 reports unimplemented special cycles; clear means silent.
// - enable bit 4 reports outside-aperture accesses; clear suppresses.
// - enable bit 3 reports invalid agp accesses.
// - enable bit 2 reports invalid translation entries.
// - enable bit 1 reports unsupported agp commands; clear means none.
`timescale 1ns/100ps
`default_nettype none
module hber_error_regs #(
  parameter int DATA_W = hber_pkg::DATA_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire hber_pkg::hber_reg_req_s i_req,
  output logic [DATA_W-1:0] o_rdata,
  input wire hber_pkg::hber_events_s i_events,
  output logic o_serr_valid,
  output logic [DATA_W-1:0] o_serr_source,
  input wire logic i_serr_ready
);

  typedef struct packed {
    logic [DATA_W-1:0] error_flags;
    logic [DATA_W-1:0] error_report_enables;
    logic [DATA_W-1:0] pci_command_register;
    logic [DATA_W-1:0] rdata;
  } hber_regs_s;

  hber_regs_s state_ff;
  hber_regs_s nxt_state;

  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;
  logic [DATA_W-1:0] rising;
  logic [DATA_W-1:0] trig_src;
  logic global_en;
  logic serr_trig;

  // map detector pulses onto flag positions
  function automatic logic [DATA_W-1:0] flag_sets(input hber_pkg::hber_events_s ev);
    logic [DATA_W-1:0] v;
    v = '0;
    v[hber_pkg::BIT_NONMEM_LOCK] = ev.nonmem_lock;
    v[hber_pkg::BIT_SW_SMI] = ev.smi & ev.smi_from_sw;
    v[hber_pkg::BIT_UNIMPL_SC] = ev.unimpl_sc;
    v[hber_pkg::BIT_OUT_APERTURE] = ev.out_aperture;
    v[hber_pkg::BIT_INVALID_AGP] = ev.invalid_agp;
    v[hber_pkg::BIT_BAD_TRANSLATION] = ev.bad_translation;
    v[hber_pkg::BIT_BAD_AGP_CMD] = ev.bad_agp_cmd;
    return v & hber_pkg::ERR_FLAGS_MASK;
  endfunction

  // plain read/write field, reserved bits forced to zero
  function automatic logic [DATA_W-1:0] rw_update(
    input logic [DATA_W-1:0] wdata,
    input logic [DATA_W-1:0] mask
  );
    return wdata & mask;
  endfunction

  always_comb
  begin
    nxt_state = state_ff;
    set_vec = flag_sets(i_events);
    clr_vec = hber_pkg::ZERO_WORD;
    if (i_req.wr && (i_req.addr == hber_pkg::ERR_FLAGS_OFS))
    begin
      clr_vec = i_req.wdata & hber_pkg::ERR_FLAGS_MASK;
    end
    // set beats clear so an event in the clearing cycle survives
    nxt_state.error_flags = (state_ff.error_flags & ~clr_vec) | set_vec;

    if (i_req.wr && (i_req.addr == hber_pkg::ERR_EN_OFS))
    begin
      nxt_state.error_report_enables = rw_update(i_req.wdata, hber_pkg::ERR_EN_MASK);
    end
    else if (i_req.wr && (i_req.addr == hber_pkg::PCI_CMD_OFS))
    begin
      nxt_state.pci_command_register = rw_update(i_req.wdata, hber_pkg::PCI_CMD_MASK);
    end

    // an already-set flag hit again stays quiet until software clears it
    rising = set_vec & ~state_ff.error_flags;
    trig_src = rising & state_ff.error_report_enables;
    // via the enable mask above
    // target abort has no flag, so its pulse itself is the edge
    trig_src[hber_pkg::BIT_TARGET_ABORT] = i_events.target_abort
      & state_ff.error_report_enables[hber_pkg::BIT_TARGET_ABORT];
    global_en = state_ff.pci_command_register[hber_pkg::BIT_SERR_EN];
    serr_trig = global_en && (trig_src != hber_pkg::ZERO_WORD);

    nxt_state.rdata = hber_pkg::ZERO_WORD;
    if (i_req.rd)
    begin
      if (i_req.addr == hber_pkg::ERR_FLAGS_OFS)
      begin
        nxt_state.rdata = state_ff.error_flags;
      end
      else if (i_req.addr == hber_pkg::ERR_EN_OFS)
      begin
        nxt_state.rdata = state_ff.error_report_enables;
      end
      else if (i_req.addr == hber_pkg::PCI_CMD_OFS)
      begin
        nxt_state.rdata = state_ff.pci_command_register;
      end
      else
      begin
        nxt_state.rdata = hber_pkg::ZERO_WORD;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_ff <= '{error_flags: hber_pkg::ERR_FLAGS_RST,
                    error_report_enables: hber_pkg::ERR_EN_RST,
                    pci_command_register: hber_pkg::PCI_CMD_RST,
                    rdata: hber_pkg::ZERO_WORD};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign o_rdata = state_ff.rdata;

  // message leaves as a request to the hub link sender, no pin
  hber_serr_msg #(
    .SRC_W(DATA_W)
  ) u_serr_msg (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_trigger(serr_trig),
    .i_source(trig_src),
    .i_ready(i_serr_ready),
    .o_valid(o_serr_valid),
    .o_source(o_serr_source)
  );

endmodule
`default_nettype wire

// [design/hber_pkg.sv]
// constants and types shared by the host bridge error reporting block
package hber_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ERR_FLAGS_OFS = 8'hc8;
  localparam logic [ADDR_W-1:0] ERR_EN_OFS = 8'hca;
  localparam logic [ADDR_W-1:0] PCI_CMD_OFS = 8'h04;

  // reset values
  localparam logic [DATA_W-1:0] ERR_FLAGS_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ERR_EN_RST = 16'h0000;
  localparam logic [DATA_W-1:0] PCI_CMD_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // implemented bits; everything else reads zero
  localparam logic [DATA_W-1:0] ERR_FLAGS_MASK = 16'h033e;
  localparam logic [DATA_W-1:0] ERR_EN_MASK = 16'h027e;
  localparam logic [DATA_W-1:0] PCI_CMD_MASK = 16'h0100;

  // field positions of flags and enables (BIT_TARGET_ABORT enable only, BIT_SW_SMI flag only); BIT_SERR_EN is in the pci command register
  localparam int BIT_NONMEM_LOCK = 9;
  localparam int BIT_SW_SMI = 8;
  localparam int BIT_TARGET_ABORT = 6;
  localparam int BIT_UNIMPL_SC = 5;
  localparam int BIT_OUT_APERTURE = 4;
  localparam int BIT_INVALID_AGP = 3;
  localparam int BIT_BAD_TRANSLATION = 2;
  localparam int BIT_BAD_AGP_CMD = 1;
  localparam int BIT_SERR_EN = 8;

  // one-cycle detector pulses from the surrounding bridge logic
  typedef struct packed {
    logic nonmem_lock;
    logic smi;
    logic smi_from_sw;
    logic unimpl_sc;
    logic out_aperture;
    logic invalid_agp;
    logic bad_translation;
    logic bad_agp_cmd;
    logic target_abort;
  } hber_events_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } hber_reg_req_s;

  typedef enum logic [0:0] {
    MSG_IDLE = 1'b0,
    MSG_SEND = 1'b1
  } hber_msg_e;

endpackage

// [design/hber_serr_msg.sv]
// serr message request holder toward the hub link
`timescale 1ns/100ps
`default_nettype none
module hber_serr_msg #(
  parameter int SRC_W = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_trigger,
  input wire logic [SRC_W-1:0] i_source,
  input wire logic i_ready,
  output logic o_valid,
  output logic [SRC_W-1:0] o_source
);

  typedef struct packed {
    hber_pkg::hber_msg_e state;
    logic [SRC_W-1:0] src;
    logic [SRC_W-1:0] pend;
  } hber_msg_state_s;

  hber_msg_state_s state_ff;
  hber_msg_state_s nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff.state)
      hber_pkg::MSG_IDLE:
      begin
        if (i_trigger)
        begin
          nxt_state.state = hber_pkg::MSG_SEND;
          nxt_state.src = i_source;
        end
      end
      hber_pkg::MSG_SEND:
      begin
        // events while a message waits are merged into one follow-up
        if (i_ready)
        begin
          if (i_trigger || (state_ff.pend != '0))
          begin
            nxt_state.src = state_ff.pend | (i_trigger ? i_source : '0);
            nxt_state.pend = '0;
          end
          else
          begin
            nxt_state.state = hber_pkg::MSG_IDLE;
          end
        end
        else if (i_trigger)
        begin
          nxt_state.pend = state_ff.pend | i_source;
        end
      end
      default:
      begin
        nxt_state.state = hber_pkg::MSG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_ff <= '{state: hber_pkg::MSG_IDLE, src: '0, pend: '0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign o_valid = (state_ff.state == hber_pkg::MSG_SEND);
  assign o_source = state_ff.src;

endmodule
`default_nettype wire

// [sim/hber_hub_model.sv]
// hub link receiver model taking serr messages
`timescale 1ns/100ps
`default_nettype none
module hber_hub_model (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [15:0] i_src,
  input wire logic [2:0] i_wait,
  output logic o_ready
);
  logic [2:0] n = 3'h0;
  logic [15:0] got[$];
  initial o_ready = 1'b0;
  // ready is a one-cycle pulse after i_wait cycles, like a busy link
  always @(posedge i_clk)
  begin
    if (o_ready && i_valid)
      got.push_back(i_src);
    n <= (o_ready || !i_valid) ? 3'h0 : n + 3'h1;
    o_ready <= i_valid && !o_ready && n >= i_wait;
  end
endmodule
`default_nettype wire

// [sim/hber_error_regs_chk.sv]
// assertions on the error register block ports
`timescale 1ns/100ps
`default_nettype none
module hber_error_regs_chk #(
  parameter int DATA_W = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire hber_pkg::hber_reg_req_s i_req,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire hber_pkg::hber_events_s i_events,
  input wire logic o_serr_valid,
  input wire logic [DATA_W-1:0] o_serr_source,
  input wire logic i_serr_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic rf, re, wf, we;
  assign rf = i_req.rd && i_req.addr == 8'hc8;
  assign re = i_req.rd && i_req.addr == 8'hca;
  assign wf = i_req.wr && i_req.addr == 8'hc8 && i_events == 0;
  assign we = i_req.wr && i_req.addr == 8'hca;
  property p_hold; o_serr_valid && !i_serr_ready |=> o_serr_valid && $stable(o_serr_source); endproperty
  a_hold: assert property (p_hold) else $error("serr dropped");
  property p_src; o_serr_valid |-> o_serr_source != 0 && (o_serr_source & ~16'h027e) == 0; endproperty
  a_src: assert property (p_src) else $error("serr source");
  property p_rsv; i_req.rd |=> (o_rdata & ~16'h037e) == 0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_unm; i_req.rd && !rf && !re && i_req.addr != 8'h04 |=> o_rdata == 0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_en; we ##1 re |=> o_rdata == ($past(i_req.wdata, 2) & 16'h027e); endproperty
  a_en: assert property (p_en) else $error("enable readback");
  property p_w1c; wf ##1 (rf && i_events == 0) |=> (o_rdata & $past(i_req.wdata, 2)) == 0; endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_oa; i_events.out_aperture ##1 rf |=> o_rdata[4]; endproperty
  a_oa: assert property (p_oa) else $error("aperture flag");
  property p_lock; i_events.nonmem_lock ##1 rf |=> o_rdata[9]; endproperty
  a_lock: assert property (p_lock) else $error("lock flag");
  c_msg: cover property (o_serr_valid && i_serr_ready);
  c_wait: cover property (o_serr_valid && !i_serr_ready);
  c_w1c: cover property (wf ##1 rf);
endmodule
bind hber_error_regs hber_error_regs_chk #(.DATA_W(DATA_W)) u_chk (.i_clk(i_clk),
  .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata), .i_events(i_events),
  .o_serr_valid(o_serr_valid), .o_serr_source(o_serr_source), .i_serr_ready(i_serr_ready));
`default_nettype wire

// [sim/tb_host_bridge_error_reporting.sv]
// self-checking bench for the error register block
`timescale 1ns/100ps
`default_nettype none
module tb_host_bridge_error_reporting;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  hber_pkg::hber_reg_req_s req = '0;
  hber_pkg::hber_events_s ev = '0;
  logic [15:0] rdata, src, fl, en, gl, m, d;
  logic sv, rdy;
  logic [2:0] wt = 3'h0;
  logic [7:0] ofs[5] = '{8'hc8, 8'hca, 8'h04, 8'hc9, 8'h40};
  logic [15:0] exq[$];
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  initial forever #20 i_clk = ~i_clk;
  hber_error_regs DUT (.i_clk(i_clk), .i_reset(i_reset), .i_req(req), .o_rdata(rdata),
    .i_events(ev), .o_serr_valid(sv), .o_serr_source(src), .i_serr_ready(rdy));
  hber_hub_model hub (.i_clk(i_clk), .i_valid(sv), .i_src(src), .i_wait(wt), .o_ready(rdy));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp_rd(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch rdata exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_msg(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch serr_source exp %h got %h", e, g);
    end
  endtask
  task automatic put(input hber_pkg::hber_reg_req_s r, input hber_pkg::hber_events_s e);
    @(posedge i_clk);
    req <= r;
    ev <= e;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    put({a, v, 2'b10}, '0);
    if (a == 8'hc8) fl &= ~v;
    if (a == 8'hca) en = v & 16'h027e;
    if (a == 8'h04) gl = v & 16'h0100;
  endtask
  task automatic rd(input logic [7:0] a);
    put({a, 16'h0, 2'b01}, '0);
    put('0, '0);
    #1;
    cmp_rd(a == 8'hc8 ? fl : a == 8'hca ? en : a == 8'h04 ? gl : 16'h0, rdata);
  endtask
  // a message is expected only for newly risen or target abort causes that are enabled
  task automatic fire(input hber_pkg::hber_events_s e);
    m = {6'h0, e[8], e[7] & e[6], 2'b0, e[5:1], 1'b0};
    d = (m & ~fl | {9'h0, e[0], 6'h0}) & en & {16{gl[8]}};
    if (d != 0) exq.push_back(d);
    fl |= m;
    put('0, e);
  endtask
  // causes are spaced apart so no two messages merge
  task automatic settle;
    put('0, '0);
    repeat (14) @(posedge i_clk);
    while (exq.size() > 0 || hub.got.size() > 0)
      cmp_msg(exq.size() > 0 ? exq.pop_front() : 16'hx, hub.got.size() > 0 ? hub.got.pop_front() : 16'hx);
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      stop_test;
    end
  end
  initial
  begin
    d = 16'($urandom(91));
    fl = '0;
    en = '0;
    gl = '0;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    foreach (ofs[i]) rd(ofs[i]);
    $display("test reset done");
    foreach (ofs[i])
    begin
      wr(ofs[i], 16'($urandom));
      rd(ofs[i]);
    end
    wr(8'hca, 16'hffff);
    wr(8'h04, 16'hffff);
    $display("test access done");
    for (int i = 0; i < 10; i++)
    begin
      wt <= i[2:0];
      repeat (2)
      begin
        fire(i == 9 ? 9'h0c0 : 9'h1 << i);
        rd(8'hc8);
      end
      settle;
      wr(8'hc8, 16'hffff);
    end
    $display("test causes done");
    repeat (30)
    begin
      wt <= 3'($urandom);
      wr(8'hca, 16'($urandom));
      wr(8'h04, 16'($urandom));
      fire(9'($urandom));
      rd(8'hc8);
      wr(8'hc8, 16'($urandom));
      rd(8'hc8);
      settle;
    end
    $display("test random done");
    // load every register, then check that a mid-run reset empties them
    wr(8'hca, 16'hffff);
    wr(8'h04, 16'hffff);
    fire(9'h1fe);
    settle;
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    fl = '0;
    en = '0;
    gl = '0;
    foreach (ofs[i]) rd(ofs[i]);
    $display("test mid reset done");
    stop_test;
  end
endmodule
`default_nettype wire
